// ### src/gdf_gpio_top.sv
// three-pin direction control and output function multiplexer
// Functional notes
// - direction bit 2 sets third pin output
// - direction bit 1 sets second pin output
// - direction bit 0 sets first pin output
// - direction register at 60h resets zero
// - first selector at 61h, low nibble code
// - code 0010 drives user output value
// - code 0011 drives both-channels mute flag
// - code 0100 drives left mute flag
// - code 0101 drives right mute flag
// - code 0110 drives clock-invalid flag
// - code 1000 drives active-low warning
// - code 1001 drives serial audio output
// - code 1011 drives active-low fault
// - code 1100 drives spi controller clock
// - code 1101 drives spi controller data out
// - second selector at 62h, upper nibble rw
// - second pin uses same code set
// - third selector at 63h, same codes
// - user output values at 65h, reset zero
//
// Local design decision: the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module gdf_gpio_top (
   input wire logic MCLK,
   input wire logic RST,
   input wire logic [7:0] ADDR,
   input wire logic [7:0] WDATA,
   input wire logic WR,
   input wire logic RD,
   output logic [7:0] RDATA,
   input wire logic [2:0] PIN_IN,
   output logic [2:0] PIN_OUT,
   output logic [2:0] PIN_OE,
   input wire logic MUTE_LEFT,
   input wire logic MUTE_RIGHT,
   input wire logic CLOCK_INVALID,
   input wire logic WARNING_N,
   input wire logic FAULT_N,
   input wire logic SERIAL_AUDIO_OUT,
   input wire logic SPI_CLK,
   input wire logic SPI_DOUT
);
   localparam int NP = gdf_pkg::NUM_PINS;

   logic [7:0] dir_q;
   logic [7:0] sel_q [NP];
   logic [7:0] out_q;
   logic [7:0] rdata_q;
   logic [7:0] rdata_d;
   logic [2:0] pin_level;
   logic [2:0] pin_in_q;
   logic we_dir;
   logic we_out;
   logic [NP-1:0] we_sel;
   logic [7:0] pin_in_word;
   gdf_pkg::gdf_src_type src;

   assign src = '{mute_left: MUTE_LEFT, mute_right: MUTE_RIGHT,
                  clock_invalid: CLOCK_INVALID, warning_n: WARNING_N,
                  fault_n: FAULT_N, serial_audio_out: SERIAL_AUDIO_OUT,
                  spi_clk: SPI_CLK, spi_dout: SPI_DOUT};

   // write decode
   assign we_dir = WR && (ADDR == gdf_pkg::OFS_DIR);
   assign we_out = WR && (ADDR == gdf_pkg::OFS_OUT);
   assign we_sel[0] = WR && (ADDR == gdf_pkg::OFS_SEL0);
   assign we_sel[1] = WR && (ADDR == gdf_pkg::OFS_SEL1);
   assign we_sel[2] = WR && (ADDR == gdf_pkg::OFS_SEL2);

   gdf_reg8 #(
      .RESET_VAL(gdf_pkg::RST_DIR)
   ) u_dir (
      .clk(MCLK),
      .rst(RST),
      .we(we_dir),
      .wdata(WDATA),
      .q(dir_q)
   );

   gdf_reg8 #(
      .RESET_VAL(gdf_pkg::RST_OUT)
   ) u_out (
      .clk(MCLK),
      .rst(RST),
      .we(we_out),
      .wdata(WDATA),
      .q(out_q)
   );

   // reserved upper nibbles are stored and read back as written
   genvar gi;
   generate
      for (gi = 0; gi < NP; gi++) begin : g_pin
         gdf_reg8 #(
            .RESET_VAL(gdf_pkg::RST_SEL)
         ) u_sel (
            .clk(MCLK),
            .rst(RST),
            .we(we_sel[gi]),
            .wdata(WDATA),
            .q(sel_q[gi])
         );
         gdf_pin_mux u_mux (
            .clk(MCLK),
            .rst(RST),
            .code(sel_q[gi][gdf_pkg::SEL_CODE_LSB +: gdf_pkg::SEL_CODE_W]),
            .user_val(out_q[gi]),
            .src(src),
            .level_q(pin_level[gi])
         );
      end
   endgenerate

   assign PIN_OE[2] = dir_q[2];
   assign PIN_OE[1] = dir_q[1];
   assign PIN_OE[0] = dir_q[0];
   assign PIN_OUT = pin_level;

   // pin levels kept for diagnostic readback; inputs are synchronous
   always_ff @(posedge MCLK) begin
      if (RST) begin
         pin_in_q <= 3'h0;
      end else begin
         pin_in_q <= PIN_IN;
      end
   end
   assign pin_in_word = {5'h00, pin_in_q};

   // read mux; unmapped offsets read zero, 64h belongs to another block
   always_comb begin
      unique case (ADDR)
         gdf_pkg::OFS_DIR: rdata_d = dir_q;
         gdf_pkg::OFS_SEL0: rdata_d = sel_q[0];
         gdf_pkg::OFS_SEL1: rdata_d = sel_q[1];
         gdf_pkg::OFS_SEL2: rdata_d = sel_q[2];
         gdf_pkg::OFS_OUT: rdata_d = out_q;
         8'h66: rdata_d = pin_in_word;
         default: rdata_d = 8'h00;
      endcase
   end

   // data stands only in the cycle after the read strobe
   always_ff @(posedge MCLK) begin
      if (RST) begin
         rdata_q <= 8'h00;
      end else if (RD) begin
         rdata_q <= rdata_d;
      end else begin
         rdata_q <= 8'h00;
      end
   end
   assign RDATA = rdata_q;

   property p_dir_reset;
      @(posedge MCLK) RST |=> (PIN_OE == 3'b000);
   endproperty
   a_dir_reset: assert property (p_dir_reset)
      else $error("pins not inputs after reset");

   property p_oe_pin2;
      @(posedge MCLK) disable iff (RST)
      we_dir |=> (PIN_OE[2] == $past(WDATA[2]));
   endproperty
   a_oe_pin2: assert property (p_oe_pin2)
      else $error("third pin direction wrong");

   property p_oe_pin1;
      @(posedge MCLK) disable iff (RST)
      we_dir |=> (PIN_OE[1] == $past(WDATA[1]));
   endproperty
   a_oe_pin1: assert property (p_oe_pin1)
      else $error("second pin direction wrong");

   property p_oe_pin0;
      @(posedge MCLK) disable iff (RST)
      we_dir |=> (PIN_OE[0] == $past(WDATA[0]));
   endproperty
   a_oe_pin0: assert property (p_oe_pin0)
      else $error("first pin direction wrong");

   property p_sel1_readback;
      @(posedge MCLK) disable iff (RST)
      (we_sel[1] ##1 (RD && ADDR == 8'h62 && !WR))
         |=> (RDATA == $past(WDATA, 2));
   endproperty
   a_sel1_readback: assert property (p_sel1_readback)
      else $error("second selector readback wrong");

   property p_user_pin0;
      @(posedge MCLK) disable iff (RST)
      (we_out && sel_q[0][3:0] == 4'h2) ##1 (sel_q[0][3:0] == 4'h2)
         |=> (PIN_OUT[0] == $past(out_q[0]));
   endproperty
   a_user_pin0: assert property (p_user_pin0)
      else $error("first pin ignores user value");

   property p_pin2_warn;
      @(posedge MCLK) disable iff (RST)
      (sel_q[2][3:0] == 4'h8) |=> (PIN_OUT[2] == $past(WARNING_N));
   endproperty
   a_pin2_warn: assert property (p_pin2_warn)
      else $error("third pin does not carry warning");

   property p_pin1_fault;
      @(posedge MCLK) disable iff (RST)
      (sel_q[1][3:0] == 4'hb) |=> (PIN_OUT[1] == $past(FAULT_N));
   endproperty
   a_pin1_fault: assert property (p_pin1_fault)
      else $error("second pin does not carry fault");

   property p_pin0_spi;
      @(posedge MCLK) disable iff (RST)
      (sel_q[0][3:0] == 4'hc) |=> (PIN_OUT[0] == $past(SPI_CLK));
   endproperty
   a_pin0_spi: assert property (p_pin0_spi)
      else $error("first pin does not carry spi clock");
endmodule : gdf_gpio_top
`default_nettype wire

// ### src/gdf_pin_mux.sv
// per-pin function selector: picks the level one pin drives
`timescale 1ns/1ps
`default_nettype none
module gdf_pin_mux (
   input wire logic clk,
   input wire logic rst,
   input wire logic [3:0] code,
   input wire logic user_val,
   input wire gdf_pkg::gdf_src_type src,
   output logic level_q
);
   logic level_d;
   logic mute_both;

   assign mute_both = src.mute_left & src.mute_right;

   always_comb begin
      level_d = 1'b0;
      unique case (gdf_pkg::gdf_func_type'(code))
         gdf_pkg::FN_LOW: level_d = 1'b0;
         gdf_pkg::FN_USER: level_d = user_val;
         gdf_pkg::FN_MUTE_BOTH: level_d = mute_both;
         gdf_pkg::FN_MUTE_L: level_d = src.mute_left;
         gdf_pkg::FN_MUTE_R: level_d = src.mute_right;
         gdf_pkg::FN_CLK_INVALID: level_d = src.clock_invalid;
         gdf_pkg::FN_WARN: level_d = src.warning_n;
         gdf_pkg::FN_SERIAL_OUT: level_d = src.serial_audio_out;
         gdf_pkg::FN_FAULT: level_d = src.fault_n;
         gdf_pkg::FN_SPI_CLK: level_d = src.spi_clk;
         gdf_pkg::FN_SPI_DOUT: level_d = src.spi_dout;
         gdf_pkg::FN_RSVD1, gdf_pkg::FN_RSVD7, gdf_pkg::FN_RSVDA,
         gdf_pkg::FN_RSVDE, gdf_pkg::FN_RSVDF: level_d = 1'b0;
      endcase
   end

   // registered so the pin never glitches while the code changes
   always_ff @(posedge clk) begin
      if (rst) begin
         level_q <= 1'b0;
      end else begin
         level_q <= level_d;
      end
   end

   property p_mux_mute_both;
      @(posedge clk) disable iff (rst)
      (code == 4'h3) |=> (level_q == $past(mute_both));
   endproperty
   a_mux_mute_both: assert property (p_mux_mute_both)
      else $error("pin does not follow combined mute");

   property p_mux_reserved_low;
      @(posedge clk) disable iff (rst)
      (code == 4'h1 || code == 4'h7 || code == 4'ha || code >= 4'he)
         |=> !level_q;
   endproperty
   a_mux_reserved_low: assert property (p_mux_reserved_low)
      else $error("reserved code did not drive low");

   property p_mux_off_low;
      @(posedge clk) disable iff (rst)
      (code == 4'h0) |=> !level_q;
   endproperty
   a_mux_off_low: assert property (p_mux_off_low)
      else $error("off code did not drive low");

   property p_mux_user;
      @(posedge clk) disable iff (rst)
      (code == 4'h2) |=> (level_q == $past(user_val));
   endproperty
   a_mux_user: assert property (p_mux_user)
      else $error("user code does not follow user value");
endmodule : gdf_pin_mux
`default_nettype wire

// ### src/gdf_pkg.sv
// package for the pin direction and function multiplexer
package gdf_pkg;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 8;
   localparam int NUM_PINS = 3;
   localparam logic [7:0] OFS_DIR = 8'h60;
   localparam logic [7:0] OFS_SEL0 = 8'h61;
   localparam logic [7:0] OFS_SEL1 = 8'h62;
   localparam logic [7:0] OFS_SEL2 = 8'h63;
   localparam logic [7:0] OFS_OUT = 8'h65;
   localparam logic [7:0] RST_DIR = 8'h00;
   localparam logic [7:0] RST_SEL = 8'h00;
   localparam logic [7:0] RST_OUT = 8'h00;
   localparam int SEL_CODE_LSB = 0;
   localparam int SEL_CODE_W = 4;

   typedef enum logic [3:0] {
      FN_LOW = 4'b0000,
      FN_RSVD1 = 4'b0001,
      FN_USER = 4'b0010,
      FN_MUTE_BOTH = 4'b0011,
      FN_MUTE_L = 4'b0100,
      FN_MUTE_R = 4'b0101,
      FN_CLK_INVALID = 4'b0110,
      FN_RSVD7 = 4'b0111,
      FN_WARN = 4'b1000,
      FN_SERIAL_OUT = 4'b1001,
      FN_RSVDA = 4'b1010,
      FN_FAULT = 4'b1011,
      FN_SPI_CLK = 4'b1100,
      FN_SPI_DOUT = 4'b1101,
      FN_RSVDE = 4'b1110,
      FN_RSVDF = 4'b1111
   } gdf_func_type;

   // internal status sources that a pin can carry
   typedef struct packed {
      logic mute_left;
      logic mute_right;
      logic clock_invalid;
      logic warning_n;
      logic fault_n;
      logic serial_audio_out;
      logic spi_clk;
      logic spi_dout;
   } gdf_src_type;
endpackage : gdf_pkg

// ### src/gdf_reg8.sv
// one 8-bit software register with synchronous reset
`timescale 1ns/1ps
`default_nettype none
module gdf_reg8 #(
   parameter logic [7:0] RESET_VAL = 8'h00
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic we,
   input wire logic [7:0] wdata,
   output logic [7:0] q
);
   always_ff @(posedge clk) begin
      if (rst) begin
         q <= RESET_VAL;
      end else if (we) begin
         q <= wdata;
      end
   end
endmodule : gdf_reg8
`default_nettype wire

// ### verification/gdf_board_model.sv
// board side of the three pins: pull levels and wire resolution
`timescale 1ns/1ps
`default_nettype none
module gdf_board_model (
   input wire logic [2:0] pin_out,
   input wire logic [2:0] pin_oe,
   input wire logic [2:0] ext_level,
   output logic [2:0] pin_in
);
   // a released pin shows the board level, never the last driven value
   always_comb begin
      for (int p = 0; p < 3; p++) begin
         pin_in[p] = pin_oe[p] ? pin_out[p] : ext_level[p];
      end
   end
endmodule : gdf_board_model
`default_nettype wire

// ### verification/gdf_gpio_top_bench.sv
// self-checking bench for the pin direction and function multiplexer
`timescale 1ns/1ps
`default_nettype none
module gdf_gpio_top_bench;
   logic mclk;
   logic rst;
   logic [7:0] addr;
   logic [7:0] wdata;
   logic wr;
   logic rd;
   wire logic [7:0] rdata;
   wire logic [2:0] pin_in;
   wire logic [2:0] pin_out;
   wire logic [2:0] pin_oe;
   logic [2:0] ext_level;
   gdf_pkg::gdf_src_type src;
   int error_cnt;
   int checks_done;
   logic [7:0] rd_val;
   logic [7:0] pats [10];
   logic [2:0] u;
   logic [2:0] ep;

   gdf_gpio_top i_dut (.MCLK(mclk), .RST(rst), .ADDR(addr), .WDATA(wdata),
      .WR(wr), .RD(rd), .RDATA(rdata), .PIN_IN(pin_in), .PIN_OUT(pin_out),
      .PIN_OE(pin_oe), .MUTE_LEFT(src.mute_left),
      .MUTE_RIGHT(src.mute_right), .CLOCK_INVALID(src.clock_invalid),
      .WARNING_N(src.warning_n), .FAULT_N(src.fault_n),
      .SERIAL_AUDIO_OUT(src.serial_audio_out), .SPI_CLK(src.spi_clk),
      .SPI_DOUT(src.spi_dout));
   gdf_board_model i_board (.pin_out(pin_out), .pin_oe(pin_oe),
      .ext_level(ext_level), .pin_in(pin_in));

   initial begin
      mclk = 1'b0;
      forever #2.5 mclk = ~mclk;
   end

   task automatic report_and_stop();
      $display("checks %0d errors %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : report_and_stop

   task automatic chk_reg(input logic [7:0] act, input logic [7:0] exp);
      checks_done++;
      if (act !== exp) begin
         error_cnt++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, act, exp);
      end
   endtask : chk_reg

   task automatic chk_pin(input logic [2:0] act, input logic [2:0] exp);
      checks_done++;
      if (act !== exp) begin
         error_cnt++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, act, exp);
      end
   endtask : chk_pin

   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge mclk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge mclk);
      wr <= 1'b0;
   endtask : wr_reg

   // write then read back at once, with no idle cycle between
   task automatic wr_then_rd(input logic [7:0] a, input logic [7:0] d,
         input logic [7:0] exp);
      @(posedge mclk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge mclk);
      wr <= 1'b0;
      rd <= 1'b1;
      @(posedge mclk);
      rd <= 1'b0;
      #1 chk_reg(rdata, exp);
   endtask : wr_then_rd

   // read data stand only in the cycle after the strobe
   task automatic check_reg(input logic [7:0] a, input logic [7:0] exp);
      @(posedge mclk);
      addr <= a;
      rd <= 1'b1;
      @(posedge mclk);
      rd <= 1'b0;
      #1 chk_reg(rdata, exp);
   endtask : check_reg

   task automatic idle(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask : idle

   function automatic logic exp_level(input logic [3:0] code,
         input gdf_pkg::gdf_src_type s, input logic uv);
      case (code)
         4'h2: exp_level = uv;
         4'h3: exp_level = s.mute_left & s.mute_right;
         4'h4: exp_level = s.mute_left;
         4'h5: exp_level = s.mute_right;
         4'h6: exp_level = s.clock_invalid;
         4'h8: exp_level = s.warning_n;
         4'h9: exp_level = s.serial_audio_out;
         4'hb: exp_level = s.fault_n;
         4'hc: exp_level = s.spi_clk;
         4'hd: exp_level = s.spi_dout;
         default: exp_level = 1'b0;
      endcase
   endfunction : exp_level

   initial begin
      rst = 1'b1;
      addr = 8'h00;
      wdata = 8'h00;
      wr = 1'b0;
      rd = 1'b0;
      ext_level = 3'h7;
      src = '0;
      error_cnt = 0;
      checks_done = 0;
      // all-ones, all-zeros and one-hot patterns tell every source apart from its neighbours
      pats = '{8'hff, 8'h00, 8'h80, 8'h40, 8'h20, 8'h10, 8'h08, 8'h04,
               8'h02, 8'h01};
      repeat (16) @(posedge mclk);
      rst <= 1'b0;
      check_reg(gdf_pkg::OFS_DIR, 8'h00);
      check_reg(gdf_pkg::OFS_SEL0, 8'h00);
      check_reg(gdf_pkg::OFS_SEL1, 8'h00);
      check_reg(gdf_pkg::OFS_SEL2, 8'h00);
      check_reg(gdf_pkg::OFS_OUT, 8'h00);
      check_reg(8'h64, 8'h00);
      chk_pin(pin_oe, 3'h0);
      for (int b = 0; b < 3; b++) begin
         wr_reg(gdf_pkg::OFS_DIR, 8'h01 << b);
         idle(1);
         chk_pin(pin_oe, 3'h1 << b);
      end
      // reserved bits keep what software wrote but steer nothing
      wr_reg(gdf_pkg::OFS_DIR, 8'hf8);
      check_reg(gdf_pkg::OFS_DIR, 8'hf8);
      chk_pin(pin_oe, 3'h0);
      wr_reg(gdf_pkg::OFS_SEL0, 8'hf3);
      wr_then_rd(gdf_pkg::OFS_SEL1, 8'ha5, 8'ha5);
      wr_reg(gdf_pkg::OFS_SEL2, 8'h5c);
      wr_reg(gdf_pkg::OFS_OUT, 8'h07);
      check_reg(gdf_pkg::OFS_SEL0, 8'hf3);
      check_reg(gdf_pkg::OFS_SEL1, 8'ha5);
      check_reg(gdf_pkg::OFS_SEL2, 8'h5c);
      check_reg(gdf_pkg::OFS_OUT, 8'h07);
      wr_reg(gdf_pkg::OFS_SEL1, 8'h00);
      wr_reg(gdf_pkg::OFS_DIR, 8'h00);
      idle(3);
      check_reg(8'h66, 8'h07);
      wr_reg(gdf_pkg::OFS_DIR, 8'h02);
      idle(3);
      check_reg(8'h66, 8'h05);
      wr_reg(gdf_pkg::OFS_DIR, 8'h07);
      for (int i = 0; i < 10; i++) begin
         src <= gdf_pkg::gdf_src_type'(pats[i]);
         u = pats[i][7:5];
         wr_reg(gdf_pkg::OFS_OUT, {5'h00, u});
         for (int c = 0; c < 16; c++) begin
            wr_reg(gdf_pkg::OFS_SEL0, {4'ha, c[3:0]});
            wr_reg(gdf_pkg::OFS_SEL1, {4'h5, c[3:0]});
            wr_reg(gdf_pkg::OFS_SEL2, {4'hf, c[3:0]});
            idle(3);
            ep = {exp_level(c[3:0], src, u[2]),
               exp_level(c[3:0], src, u[1]),
               exp_level(c[3:0], src, u[0])};
            case (c[3:2])
               2'd0: chk_pin(pin_out, ep);
               2'd1: chk_pin(pin_out, ep);
               2'd2: chk_pin(pin_out, ep);
               default: chk_pin(pin_out, ep);
            endcase
         end
      end
      // user value on the first pin, written while its code is selected
      wr_reg(gdf_pkg::OFS_SEL0, 8'h02);
      wr_reg(gdf_pkg::OFS_OUT, 8'h05);
      idle(3);
      chk_pin(pin_out, 3'h1);
      // a second reset in mid-run must clear everything again
      @(posedge mclk);
      rst <= 1'b1;
      repeat (2) @(posedge mclk);
      rst <= 1'b0;
      #1 chk_pin(pin_oe, 3'h0);
      chk_pin(pin_out, 3'h0);
      check_reg(gdf_pkg::OFS_SEL1, 8'h00);
      check_reg(gdf_pkg::OFS_SEL2, 8'h00);
      check_reg(gdf_pkg::OFS_DIR, 8'h00);
      check_reg(gdf_pkg::OFS_SEL0, 8'h00);
      check_reg(gdf_pkg::OFS_OUT, 8'h00);
      report_and_stop();
   end
endmodule : gdf_gpio_top_bench
`default_nettype wire
